// ===== eepl_pkg.sv
package eepl_pkg;
    // Pin output modes
    typedef enum logic [1:0] {
        EEPL_MODE_IDLE,
        EEPL_MODE_EVENT,
        EEPL_MODE_COUNT
    } eepl_mode_t;

    // Number of event pins
    localparam int EEPL_NPINS = 2;
    localparam int EEPL_HALT_PIN = 0;
    localparam int EEPL_CARRY_PIN = 1;
    // Test clock period and pulse bounds in ns
    localparam int EEPL_TCK_NS = 30;
    localparam int EEPL_PULSE_MAX_NS = 10000;
    localparam int EEPL_CLK_NS = 40;
    // Pulse length in system clocks: above one test clock, below 10 us
    localparam int EEPL_PULSE_MIN_CYC = (EEPL_TCK_NS + EEPL_CLK_NS - 1)
        / EEPL_CLK_NS + 1;
    localparam int EEPL_PULSE_MAX_CYC = (EEPL_PULSE_MAX_NS - 1) / EEPL_CLK_NS;
    localparam int EEPL_PULSE_CYC = 4;
    localparam int EEPL_CNT_W = 16;
    localparam logic [EEPL_CNT_W-1:0] EEPL_CNT_RST = 16'h0000;
    localparam logic [1:0] EEPL_PINS_HIGH = 2'h3;
endpackage : eepl_pkg

// ===== eepl_bus_if.sv
`timescale 1ns/10ps
// Shared event lines between the device pins and the board logic
interface eepl_bus_if;
    logic [1:0] dev_out;
    logic [1:0] dev_oe;
    logic [1:0] ext_out;
    logic [1:0] ext_oe;
    logic [1:0] event_out_line;
    logic [1:0] event_in_line;
    logic count_mode_gate;

    // Open-collector wiring with pull-up: any driver low pulls low
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_wire
            assign event_out_line[g] =
                (dev_oe[g] & ~dev_out[g]) ? 1'b0 :
                (ext_oe[g] & ~ext_out[g]) ? 1'b0 :
                (dev_oe[g] ? dev_out[g] : 1'b1);
        end
    endgenerate

    modport device (
        output dev_out,
        output dev_oe,
        input event_in_line
    );
    modport board (
        input event_out_line,
        output ext_out,
        output ext_oe,
        output event_in_line,
        output count_mode_gate
    );
endinterface : eepl_bus_if

// ===== eepl_pulse_gen.sv
`timescale 1ns/10ps
// One event-out line to one bounded event-in pulse
module eepl_pulse_gen
    import eepl_pkg::*;
#(
    parameter int PULSE_CYC = EEPL_PULSE_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_line_sync,
    input wire logic i_gate,
    output logic o_in_line
);
    logic [EEPL_CNT_W-1:0] cnt_r;
    logic armed_r;
    logic out_r;
    wire start = armed_r & ~i_line_sync & ~i_gate;
    wire done = (cnt_r == EEPL_CNT_W'(1));

    // Pulse timer and rearm on return high
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cnt_r <= EEPL_CNT_RST;
            armed_r <= 1'b1;
            out_r <= 1'b1;
        end else if (i_gate) begin
            cnt_r <= EEPL_CNT_RST;
            out_r <= 1'b1;
            armed_r <= i_line_sync;
        end else if (start) begin
            cnt_r <= EEPL_CNT_W'(PULSE_CYC);
            out_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            if (cnt_r != EEPL_CNT_RST) cnt_r <= cnt_r - 1'b1;
            if (done) out_r <= 1'b1;
            if (i_line_sync && cnt_r == EEPL_CNT_RST) armed_r <= 1'b1;
        end
    end
    assign o_in_line = out_r;
endmodule : eepl_pulse_gen

// ===== eepl_board.sv
`timescale 1ns/10ps
// Board logic: pulse generators, analyser port, scan reset
module eepl_board
    import eepl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    eepl_bus_if.board bus,
    input wire logic i_count_mode_gate,
    input wire logic [1:0] i_analyser_pull,
    input wire logic i_controller_event3_output,
    output logic [1:0] o_event_out_line,
    output logic o_test_rst_n
);
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic gate_r;
    logic trst_n_r;
    logic [1:0] an_r;
    logic [1:0] in_line;

    // Synchronise bused lines; register controls
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s1_r <= EEPL_PINS_HIGH;
            s2_r <= EEPL_PINS_HIGH;
            gate_r <= 1'b0;
            trst_n_r <= 1'b0;
            an_r <= 2'h0;
        end else begin
            s1_r <= bus.event_out_line;
            s2_r <= s1_r;
            gate_r <= i_count_mode_gate;
            trst_n_r <= ~i_controller_event3_output;
            an_r <= i_analyser_pull & {2{~i_count_mode_gate}};
        end
    end

    genvar g;
    generate
        for (g = 0; g < EEPL_NPINS; g++) begin : g_pg
            eepl_pulse_gen u_pg (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_line_sync(s2_r[g]),
                .i_gate(gate_r),
                .o_in_line(in_line[g])
            );
        end
    endgenerate

    // Analyser drives only open-collector low
    assign bus.ext_out = 2'h0;
    assign bus.ext_oe = an_r;
    assign bus.event_in_line = in_line;
    assign bus.count_mode_gate = gate_r;
    assign o_event_out_line = s2_r;
    assign o_test_rst_n = trst_n_r;
endmodule : eepl_board

// ===== eepl_device.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Pins released unless a mode is active
// - Event mode pulls pin low, else releases
// - Other sources drive lines open-collector only
// - Count mode drives pins push-pull
// - Other sources idle during count mode
// - Enabled halt when either pin low
// - Count mode: carry on pin1, halted pin0
// - Board pulses event-in on low event-out
// - Pulse longer than TCK, under 10 us
// - Board holds event-in high during count
// - Board splits lines into in and out
// - Scan reset from inverted controller event3
// - Scan reset reaches every chained device; the board only drives o_test_rst_n, and eepl_device has no scan reset input
module eepl_device
    import eepl_pkg::*;
#(
    parameter int CNT_W = EEPL_CNT_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_link_clk,
    eepl_bus_if.device bus,
    input wire logic [1:0] i_mode,
    input wire logic i_halt_enable,
    input wire logic [1:0] i_event,
    input wire logic i_halt_clear,
    input wire logic i_count_tick,
    output logic o_halted,
    output logic [1:0] o_event_in_seen
);
    // Count mode decode, used in both clock domains
    function automatic logic is_count_mode(input logic [1:0] m);
        return m == EEPL_MODE_COUNT;
    endfunction : is_count_mode

    // System domain: registered controls
    logic [1:0] mode_r;
    logic [1:0] ev_r;
    logic halt_en_r;
    logic tick_tog_r;
    // System domain: event-in sync and halt flag
    logic [1:0] in1_r;
    logic [1:0] in2_r;
    logic [1:0] seen_r;
    logic halted_r;
    // Link domain: reset synchroniser
    logic lrst1_r;
    logic lrst2_r;
    // Link domain: control synchronisers
    logic [1:0] lm1_r;
    logic [1:0] lm2_r;
    logic [1:0] lm3_r;
    logic [1:0] lmode_r;
    logic [1:0] le1_r;
    logic [1:0] le2_r;
    logic lh1_r;
    logic lh2_r;
    logic lt1_r;
    logic lt2_r;
    logic lt3_r;
    // Link domain: counter and pin drivers
    logic [CNT_W-1:0] cnt_r;
    logic carry_r;
    logic [1:0] pin_out_r;
    logic [1:0] pin_oe_r;

    // Halt set by a low event-in line; set beats clear
    wire pin_low = ~(&in2_r);
    wire halt_set = halt_en_r & pin_low;
    wire halt_nxt = halt_set | (halted_r & ~i_halt_clear);
    // Steps outside count mode are dropped here
    wire tick_take = i_count_tick & is_count_mode(mode_r);
    wire tick_tog_nxt = tick_tog_r ^ tick_take;

    // Register controls from the system side
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            mode_r <= 2'h0;
            ev_r <= 2'h0;
            halt_en_r <= 1'b0;
        end else begin
            mode_r <= i_mode;
            ev_r <= i_event;
            halt_en_r <= i_halt_enable;
        end
    end

    // Two-stage sync of the event-in lines
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            in1_r <= EEPL_PINS_HIGH;
            in2_r <= EEPL_PINS_HIGH;
            seen_r <= 2'h0;
        end else begin
            in1_r <= bus.event_in_line;
            in2_r <= in1_r;
            seen_r <= ~in2_r;
        end
    end

    // Sticky halt flag
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            halted_r <= 1'b0;
        end else begin
            halted_r <= halt_nxt;
        end
    end

    // Count steps cross to the link side as a toggle
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tick_tog_r <= 1'b0;
        end else begin
            tick_tog_r <= tick_tog_nxt;
        end
    end

    // Reset reaches the link domain through two flip-flops
    always_ff @(posedge i_link_clk) begin
        lrst1_r <= i_sys_rst;
        lrst2_r <= lrst1_r;
    end

    // Mode word is taken only once two samples agree
    wire link_rst = lrst2_r;
    wire mode_stable = (lm2_r == lm3_r);
    wire [1:0] lmode_nxt = mode_stable ? lm2_r : lmode_r;
    wire eepl_mode_t link_mode = eepl_mode_t'(lmode_r);
    wire tick_ev = lt2_r ^ lt3_r;
    wire count_step = is_count_mode(lmode_r) & tick_ev;
    wire [CNT_W:0] cnt_sum = {1'b0, cnt_r} + {{CNT_W{1'b0}}, 1'b1};

    // Control synchronisers into the link domain
    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            lm1_r <= 2'h0;
            lm2_r <= 2'h0;
            lm3_r <= 2'h0;
            lmode_r <= 2'h0;
            le1_r <= 2'h0;
            le2_r <= 2'h0;
            lh1_r <= 1'b0;
            lh2_r <= 1'b0;
            lt1_r <= 1'b0;
            lt2_r <= 1'b0;
            lt3_r <= 1'b0;
        end else begin
            lm1_r <= mode_r;
            lm2_r <= lm1_r;
            lm3_r <= lm2_r;
            lmode_r <= lmode_nxt;
            le1_r <= ev_r;
            le2_r <= le1_r;
            lh1_r <= halted_r;
            lh2_r <= lh1_r;
            lt1_r <= tick_tog_r;
            lt2_r <= lt1_r;
            lt3_r <= lt2_r;
        end
    end

    // Internal counter; carry stands one link cycle on wrap
    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            cnt_r <= '0;
            carry_r <= 1'b0;
        end else if (count_step) begin
            cnt_r <= cnt_sum[CNT_W-1:0];
            carry_r <= cnt_sum[CNT_W];
        end else begin
            carry_r <= 1'b0;
        end
    end

    // Pin drivers per output mode
    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            pin_out_r <= EEPL_PINS_HIGH;
            pin_oe_r <= 2'h0;
        end else begin
            case (link_mode)
                EEPL_MODE_EVENT: begin
                    pin_out_r <= 2'h0;
                    pin_oe_r <= le2_r;
                end
                EEPL_MODE_COUNT: begin
                    pin_out_r[EEPL_CARRY_PIN] <= ~carry_r;
                    pin_out_r[EEPL_HALT_PIN] <= lh2_r;
                    pin_oe_r <= EEPL_PINS_HIGH;
                end
                default: begin
                    pin_out_r <= EEPL_PINS_HIGH;
                    pin_oe_r <= 2'h0;
                end
            endcase
        end
    end

    assign bus.dev_out = pin_out_r;
    assign bus.dev_oe = pin_oe_r;
    assign o_halted = halted_r;
    assign o_event_in_seen = seen_r;
endmodule : eepl_device

// ===== eepl_checker.sv
`timescale 1ns/10ps
// Watches the shared event lines between both ends
module eepl_checker (
    input wire logic i_clk,
    input wire logic i_link_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] dev_out,
    input wire logic [1:0] dev_oe,
    input wire logic [1:0] ext_out,
    input wire logic [1:0] ext_oe,
    input wire logic [1:0] event_out_line,
    input wire logic [1:0] event_in_line,
    input wire logic count_mode_gate
);
    // Board side on the system clock
    chk_ext_pull_only: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) (ext_oe & ext_out) == 2'h0)
        else $error("ext driver high");
    chk_ext_idle_count: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) count_mode_gate && $past(count_mode_gate, 2)
        |-> ext_oe == 2'h0) else $error("ext active in count");
    chk_in_held_count: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) count_mode_gate && $past(count_mode_gate, 2)
        |-> event_in_line == 2'h3) else $error("event in low in count");
    chk_pulse_len: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) $fell(event_in_line[0])
        |-> (!event_in_line[0])[*4] ##1 event_in_line[0])
        else $error("pulse length");
    chk_pulse_start: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) $fell(event_out_line[1]) && !count_mode_gate
        |-> ##[1:6] !event_in_line[1]) else $error("no pulse");
    chk_one_pulse: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) (!event_out_line[0] && !count_mode_gate)[*8]
        |=> event_in_line[0]) else $error("retrigger");
    // Device side on the link clock
    chk_dev_pull_only: assert property (@(posedge i_link_clk)
        disable iff (i_sys_rst) !count_mode_gate |-> (dev_oe & dev_out) == 2'h0)
        else $error("device drives high");
    chk_carry_short: assert property (@(posedge i_link_clk)
        disable iff (i_sys_rst) count_mode_gate && dev_oe[1] && !dev_out[1]
        |=> dev_out[1] || !dev_oe[1]) else $error("carry too long");
endmodule : eepl_checker

// ===== tb_emulation_event_pin_logic.sv
`timescale 1ns/10ps
// Both ends joined across the shared event lines
module tb_emulation_event_pin_logic;
    import eepl_pkg::*;
    logic i_clk, i_link_clk, i_sys_rst, i_halt_enable, i_halt_clear;
    logic i_count_tick, i_count_mode_gate, ev3, o_halted, o_test_rst_n, hen;
    logic [1:0] i_mode, i_event, i_analyser_pull, o_event_in_seen, out_line;
    int num_errors = 0, n_checks = 0, seed = 32'ha6583216, carries = 0, g;
    int n_ticks;
    localparam int TB_CNT_W = 3;
    eepl_bus_if bus ();
    eepl_device #(.CNT_W(TB_CNT_W)) u_eepl_device (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk), .bus(bus),
        .i_mode(i_mode), .i_halt_enable(i_halt_enable), .i_event(i_event),
        .i_halt_clear(i_halt_clear), .i_count_tick(i_count_tick),
        .o_halted(o_halted), .o_event_in_seen(o_event_in_seen));
    eepl_board u_eepl_board (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .bus(bus), .i_count_mode_gate(i_count_mode_gate),
        .i_analyser_pull(i_analyser_pull), .i_controller_event3_output(ev3),
        .o_event_out_line(out_line), .o_test_rst_n(o_test_rst_n));
    eepl_checker u_eepl_checker (.i_clk(i_clk), .i_link_clk(i_link_clk),
        .i_sys_rst(i_sys_rst), .dev_out(bus.dev_out), .dev_oe(bus.dev_oe),
        .ext_out(bus.ext_out), .ext_oe(bus.ext_oe),
        .event_out_line(bus.event_out_line),
        .event_in_line(bus.event_in_line),
        .count_mode_gate(bus.count_mode_gate));
    // Clocks: system 40 ns, link 30 ns with an offset
    initial begin
        i_clk = 0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        i_link_clk = 0;
        #7;
        forever #15 i_link_clk = ~i_link_clk;
    end
    // Count carry pulses seen on pin 1
    always @(negedge i_link_clk)
        if (i_mode === 2'h2 && bus.dev_oe[1] === 1'b1 && !bus.dev_out[1])
            carries++;
    function automatic logic [1:0] low_bit(input int b);
        return ~(2'h1 << b);
    endfunction : low_bit
    // Carries expected from a number of steps on a w-bit counter
    function automatic logic [1:0] carry_count(input int ticks, input int w);
        return 2'(ticks >> w);
    endfunction : carry_count
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    task automatic chk(input string s, input logic [1:0] e, logic [1:0] v);
        n_checks++;
        if (v !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, v);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    // Bounded wait for an event-in pulse
    task automatic wait_in(input int b);
        int k;
        for (k = 0; k < 40 && bus.event_in_line[b] !== 1'b0; k++) cyc(1);
        if (k == 40) begin
            chk("event_in_line", 2'h0, 2'h1);
            conclude();
        end
    endtask : wait_in
    initial begin
        {i_sys_rst, i_mode, i_event, i_analyser_pull} = 7'h40;
        {i_halt_enable, i_halt_clear, i_count_tick, i_count_mode_gate} = 4'h0;
        ev3 = 0;
        cyc(16);
        chk("test_rst_n", 2'h0, {1'b0, o_test_rst_n});
        i_sys_rst = 0;
        cyc(4);
        chk("test_rst_n", 2'h1, {1'b0, o_test_rst_n});
        chk("dev_oe", 2'h0, bus.dev_oe);
        ev3 = 1;
        cyc(3);
        chk("test_rst_n", 2'h0, {1'b0, o_test_rst_n});
        // Events from each pin, then from the analyser
        for (int i = 0; i < 6; i++) begin
            g = i % 2;
            hen = 1'($random(seed));
            i_mode = EEPL_MODE_EVENT;
            i_halt_enable = hen;
            if (i >= 4) i_analyser_pull[g] = 1'b1;
            else i_event[g] = 1'b1;
            wait_in(g);
            chk("event_out_line", low_bit(g), bus.event_out_line);
            chk("o_event_out_line", low_bit(g), out_line);
            cyc(3);
            chk("event_in_seen", ~low_bit(g), o_event_in_seen);
            cyc(8 + ($random(seed) & 7));
            chk("event_in_line", 2'h3, bus.event_in_line);
            chk("halted", {1'b0, hen}, {1'b0, o_halted});
            i_event = 0;
            i_analyser_pull = 0;
            cyc(12);
            chk("event_in_line", 2'h3, bus.event_in_line);
            i_halt_clear = 1;
            cyc(1);
            i_halt_clear = 0;
            cyc(2);
            chk("halted", 2'h0, {1'b0, o_halted});
        end
        // Count run: gate first, analyser pulling
        {i_mode, i_halt_enable, i_count_mode_gate} = 4'h1;
        cyc(4);
        i_mode = EEPL_MODE_COUNT;
        i_analyser_pull = 2'h3;
        cyc(8);
        chk("dev_oe", 2'h3, bus.dev_oe);
        chk("ext_oe", 2'h0, bus.ext_oe);
        chk("halt_pin", 2'h0, {1'b0, bus.dev_out[0]});
        chk("event_in_line", 2'h3, bus.event_in_line);
        n_ticks = 9 + ($random(seed) & 15);
        for (int t = 0; t < n_ticks; t++) begin
            i_count_tick = 1;
            cyc(1);
            i_count_tick = 0;
            cyc(2 + ($random(seed) & 1));
        end
        cyc(8);
        chk("carries", carry_count(n_ticks, TB_CNT_W),
            (carries > 3) ? 2'h3 : 2'(carries));
        i_analyser_pull = 0;
        i_mode = EEPL_MODE_IDLE;
        cyc(10);
        chk("dev_oe", 2'h0, bus.dev_oe);
        i_count_mode_gate = 0;
        cyc(10);
        conclude();
    end
endmodule : tb_emulation_event_pin_logic
